// [dv/ilpu_checker.sv]
// assertions on the priority unit's core link and bus answers
`timescale 1ns/1ps
`default_nettype none
module ilpu_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        flag_sample_point,
	input wire        final_cycle,
	input wire        status_change_insn,
	input wire        call_ack,
	input wire        call_req,
	input wire [15:0] call_vector,
	input wire [11:0] flag_clear
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wait; call_req && !call_ack; endsequence
	sequence s_take; call_req && call_ack; endsequence
	property p_grant;
		$rose(call_req) |-> $past(flag_sample_point && final_cycle && !status_change_insn);
	endproperty
	property p_hold; s_wait |=> call_req; endproperty
	property p_ack; s_take |=> !call_req; endproperty
	property p_clr; flag_clear != 12'h000 |-> $past(call_req && call_ack); endproperty
	property p_noclr; (flag_clear & 12'h546) == 12'h000; endproperty
	property p_vec; s_wait ##0 !flag_sample_point |=> $stable(call_vector); endproperty
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	a_grant: assert property (p_grant) else $error("call without a final poll");
	a_hold: assert property (p_hold) else $error("call dropped before ack");
	a_ack: assert property (p_ack) else $error("call kept after ack");
	a_clr: assert property (p_clr) else $error("flag clear without ack");
	a_noclr: assert property (p_noclr) else $error("software flag cleared");
	a_vec: assert property (p_vec) else $error("vector moved off poll");
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule // ilpu_checker
bind four_level_interrupt_priority_unit ilpu_checker i_ilpu_checker (.aclk(aclk),
	.aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .call_ack(call_ack),
	.flag_sample_point(flag_sample_point), .final_cycle(final_cycle), .call_req(call_req),
	.status_change_insn(status_change_insn), .call_vector(call_vector), .flag_clear(flag_clear));
`default_nettype wire

// [dv/ilpu_core_model.sv]
// core model: machine cycles, instruction ends, two-cycle hardware call
`timescale 1ns/1ps
`default_nettype none
module ilpu_core_model (
	input  wire  aclk,
	input  wire  aresetn,
	input  wire  call_req,
	input  wire  insn_last,
	input  wire  insn_status,
	input  wire  do_rfi,
	output logic call_ack,
	output logic flag_sample_point,
	output logic final_cycle,
	output logic status_change_insn,
	output logic return_from_interrupt
);
	logic [1:0] phase_q;
	logic       wait_q;
	assign flag_sample_point = (phase_q == 2'h3);
	assign final_cycle = insn_last;
	assign status_change_insn = insn_status;
	assign return_from_interrupt = do_rfi;
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= 2'h0;
			wait_q <= 1'b0;
			call_ack <= 1'b0;
		end else begin
			phase_q <= phase_q + 2'h1;
			wait_q <= call_req && !call_ack;
			call_ack <= wait_q && call_req && !call_ack;
		end
	end
endmodule // ilpu_core_model
`default_nettype wire

// [dv/tb_four_level_interrupt_priority_unit.sv]
// self-checking bench for the interrupt priority unit
`include "ilpu_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_four_level_interrupt_priority_unit;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [9:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [13:0] fl = 0, f;
	logic        insn_last = 1, insn_status = 0, do_rfi = 0;
	logic [5:0]  lo = 0, hi = 0;
	logic [1:0]  e;
	wire         awready, wready, arready, bvalid, rvalid, call_req, call_ack, fsp, fc, sci, rfi;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [15:0] vec;
	wire  [11:0] fclr;
	int          n_fail = 0, check_count = 0, n_ack = 0, x, a;
	int          lvl_q[$];
	logic [15:0] vt[12] = '{16'h0003, 16'h0043, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
		16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};
	four_level_interrupt_priority_unit i_four_level_interrupt_priority_unit (.aclk(aclk),
		.aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flag_sample_point(fsp),
		.final_cycle(fc), .status_change_insn(sci), .return_from_interrupt(rfi),
		.ext0_request_flag(fl[0]), .converter_done_flag(fl[1]), .timer0_overflow_flag(fl[2]),
		.ext2_request_flag(fl[3]), .ext1_request_flag(fl[4]), .ext3_request_flag(fl[5]),
		.timer1_overflow_flag(fl[6]), .ext4_request_flag(fl[7]), .receive_done_flag(fl[8]),
		.ext5_request_flag(fl[9]), .timer2_overflow_flag(fl[10]), .ext6_request_flag(fl[11]),
		.transmit_done_flag(fl[12]), .timer2_reload_flag(fl[13]), .call_ack(call_ack),
		.call_req(call_req), .call_vector(vec), .flag_clear(fclr));
	ilpu_core_model i_ilpu_core_model (.aclk(aclk), .aresetn(aresetn), .call_req(call_req),
		.insn_last(insn_last), .insn_status(insn_status), .do_rfi(do_rfi), .call_ack(call_ack),
		.flag_sample_point(fsp), .final_cycle(fc), .status_change_insn(sci),
		.return_from_interrupt(rfi));
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) if (call_req && call_ack) n_ack++;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [9:0] ad, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		@(negedge aclk iff awready);
		@(posedge aclk);
		awv <= 1'b0;
		wv <= 1'b0;
		@(negedge aclk iff bvalid);
		@(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] ad, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= ad;
		arv <= 1'b1;
		@(negedge aclk iff arready);
		@(posedge aclk);
		arv <= 1'b0;
		@(negedge aclk iff rvalid);
		check("rdata", rdata, ed);
		check("rresp", 32'(rresp), 32'(er));
		@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic mc(input int n);
		repeat (n) @(negedge aclk iff fsp);
	endtask
	function automatic int lvl(input int s);
		return int'({hi[s/2], lo[s/2]});
	endfunction
	function automatic int pick(input logic [13:0] q, input int cur);
		int b = -1;
		for (int s = 0; s < 12; s++)
			if ((q[s] || (s == 8 && q[12]) || (s == 10 && q[13])) && lvl(s) > cur)
				if (b < 0 || lvl(s) > lvl(b)) b = s;
		return b;
	endfunction
	task automatic serve(input int s);
		@(negedge aclk iff call_req);
		check("vector", vec, vt[s]);
		@(negedge aclk iff !call_req);
		check("clear", fclr, (12'h1 << s) & (12'hAA8 | {7'h0, e[1], 3'h0, e[0]}));
		lvl_q.push_back(lvl(s));
		@(posedge aclk);
		fl <= 14'h0;
		mc(2);
	endtask
	task automatic leave_isr();
		@(posedge aclk);
		do_rfi <= 1'b1;
		@(posedge aclk);
		do_rfi <= 1'b0;
		void'(lvl_q.pop_back());
	endtask
	initial begin
		#500us;
		n_fail++;
		summarize();
	end
	initial begin
		void'($urandom(32'h8316e2b0));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(10'h2A4, 0, `RESP_OKAY);
		rd(10'h2E4, 0, `RESP_OKAY);
		wr(10'h2A4, 32'hFF);
		rd(10'h2A4, 32'h3F, `RESP_OKAY);
		wr(10'h2A4, 32'h0);
		rd(10'h3FC, 0, `RESP_SLVERR);
		$display("test registers done");
		e = 2'($urandom);
		for (int s = 0; s < 12; s++) begin
			wr(10'h2A0, (32'h1 << s) | 32'h1000 | {14'h0, e, 16'h0});
			f = 14'($urandom) | (14'h1 << (s == 8 ? 12 : s == 10 ? 13 : s));
			@(posedge aclk);
			fl <= f;
			serve(s);
			leave_isr();
		end
		f = 14'h0800;
		insn_last <= 1'b0;
		fl <= f;
		x = n_ack;
		mc(4);
		check("held", n_ack, x);
		@(posedge aclk);
		insn_last <= 1'b1;
		serve(11);
		leave_isr();
		insn_status <= 1'b1;
		fl <= f;
		mc(4);
		@(posedge aclk);
		insn_status <= 1'b0;
		mc(2);
		check("stalled", n_ack, x + 1);
		serve(11);
		leave_isr();
		$display("test single sources done");
		wr(10'h2A0, 32'h1FFF | {14'h0, e, 16'h0});
		for (int i = 0; i < 40; i++) begin
			lo = 6'($urandom);
			hi = 6'($urandom);
			wr(10'h2A4, {26'h0, lo});
			wr(10'h2E4, {26'h3FFFFFF, hi});
			f = 14'($urandom);
			a = pick(f, lvl_q.size() ? lvl_q[$] : -1);
			x = n_ack;
			@(posedge aclk);
			fl <= f;
			if (a >= 0) serve(a);
			else begin
				mc(4);
				check("blocked", n_ack, x);
				@(posedge aclk);
				fl <= 14'h0;
				mc(2);
			end
			if (lvl_q.size() && $urandom % 2) leave_isr();
		end
		$display("test random nesting done");
		summarize();
	end
endmodule // tb_four_level_interrupt_priority_unit
`default_nettype wire

// [src/four_level_interrupt_priority_unit.v]
// four-level interrupt priority and vectoring unit with AXI4-Lite registers
// Functional notes
// - only low six bits of both priority registers set group levels
// - group level = {high bit, low bit}; 00 lowest, 11 highest
// - groups: ext0/adc, t0/ext2, ext1/ext3, t1/ext4, serial/ext5, t2/ext6
// - running routine preempted only by strictly higher level
// - level-3 routine blocks all requests until it returns
// - highest pending level wins a poll
// - equal level: lower group first, first source before partner
// - flags captured at sample point, next sample point polls captured values
// - no call while equal or higher level already in progress
// - call only when poll coincides with final instruction cycle
// - return-from-interrupt or enable/priority write delays vectoring only when the core flags it on status_change_insn
// - blocked requests are not remembered; polls see current flags
// - higher request before next sample point may take over pending call
// - ext0/ext1 flags cleared on vectoring only when edge-triggered
// - acknowledge is a two-cycle hardware call by the core
// - vectors 0003,000B,0013,001B,0023,002B for ext0, t0, ext1, t1, serial, t2
// - vectors 0043,004B,0053,005B,0063,006B for adc and ext2..6
// - return-from-interrupt clears current level's in-progress marker
// - plain subroutine return leaves in-progress markers alone
// - timer 2 request is overflow OR reload, never cleared here
// - serial request is receive OR transmit, never cleared here
// - ext2..ext6 flags cleared by hardware on vectoring
// - converter-done flag not cleared on vectoring
`include "ilpu_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module four_level_interrupt_priority_unit (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire                 clk_en,
	input  wire [`ADDR_W-1:0]   s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [`ADDR_W-1:0]   s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output reg  [31:0]          s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready,
	input  wire                 flag_sample_point,
	input  wire                 final_cycle,
	input  wire                 status_change_insn,
	input  wire                 return_from_interrupt,
	input  wire                 ext0_request_flag,
	input  wire                 converter_done_flag,
	input  wire                 timer0_overflow_flag,
	input  wire                 ext2_request_flag,
	input  wire                 ext1_request_flag,
	input  wire                 ext3_request_flag,
	input  wire                 timer1_overflow_flag,
	input  wire                 ext4_request_flag,
	input  wire                 receive_done_flag,
	input  wire                 transmit_done_flag,
	input  wire                 ext5_request_flag,
	input  wire                 timer2_overflow_flag,
	input  wire                 timer2_reload_flag,
	input  wire                 ext6_request_flag,
	input  wire                 call_ack,
	output reg                  call_req,
	output reg  [15:0]          call_vector,
	output reg  [11:0]          flag_clear
);

	localparam [`ADDR_W-1:0] A_PLOW = {`IDX_PRIO_LOW, 2'b00};
	localparam [`ADDR_W-1:0] A_PHIGH = {`IDX_PRIO_HIGH, 2'b00};
	localparam [`ADDR_W-1:0] A_EN = {`IDX_ENABLE, 2'b00};
	localparam [`ADDR_W-1:0] A_STAT = {`IDX_STATUS, 2'b00};

	reg  [`PRIO_BITS-1:0] prio_low_q;
	reg  [`PRIO_BITS-1:0] prio_high_q;
	reg  [17:0]           enable_q;
	reg  [11:0]           captured_q;
	reg  [3:0]            in_prog_q;
	reg  [3:0]            sel_src_q;
	reg  [1:0]            sel_lvl_q;
	reg                   stall_q;

	// raw requests in arbitration order, two per group
	wire [11:0] raw_req;
	assign raw_req = {ext6_request_flag,
		timer2_overflow_flag | timer2_reload_flag,
		ext5_request_flag,
		receive_done_flag | transmit_done_flag,
		ext4_request_flag, timer1_overflow_flag,
		ext3_request_flag, ext1_request_flag,
		ext2_request_flag, timer0_overflow_flag,
		converter_done_flag, ext0_request_flag};

	wire [11:0] gated_req;
	assign gated_req = raw_req & enable_q[11:0]
		& {12{enable_q[`EN_GLOBAL_BIT]}};

	// level per source from its group's two priority bits
	wire [1:0] src_lvl [0:11];
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_lvl
			assign src_lvl[gi] = {prio_high_q[gi/2], prio_low_q[gi/2]};
		end
	endgenerate

	// winner: highest level, then lowest index
	reg       win_valid;
	reg [3:0] win_src;
	reg [1:0] win_lvl;
	integer   i;
	always @* begin
		win_valid = 1'b0;
		win_src = 4'h0;
		win_lvl = 2'h0;
		for (i = 11; i >= 0; i = i - 1) begin
			if (captured_q[i] && (!win_valid || src_lvl[i] >= win_lvl)) begin
				win_valid = 1'b1;
				win_src = i[3:0];
				win_lvl = src_lvl[i];
			end
		end
	end

	// highest level now in progress
	reg       busy;
	reg [1:0] top_lvl;
	always @* begin
		busy = |in_prog_q;
		top_lvl = in_prog_q[3] ? 2'h3 : in_prog_q[2] ? 2'h2 :
			in_prog_q[1] ? 2'h1 : 2'h0;
	end

	wire level_ok;
	assign level_ok = !busy || (win_lvl > top_lvl);

	// a status-changing instruction stalls through the next instruction
	wire insn_ok;
	assign insn_ok = final_cycle && !status_change_insn && !stall_q;

	wire grant;
	assign grant = flag_sample_point && win_valid && level_ok && insn_ok;

	// pending call may be overtaken by a strictly higher level
	wire overtake;
	assign overtake = call_req && flag_sample_point && win_valid
		&& (win_lvl > sel_lvl_q) && level_ok;

	function [15:0] vec_of;
		input [3:0] s;
		begin
			case (s)
				4'h0: vec_of = `VEC_EXT0;
				4'h1: vec_of = `VEC_ADC;
				4'h2: vec_of = `VEC_T0;
				4'h3: vec_of = `VEC_EXT2;
				4'h4: vec_of = `VEC_EXT1;
				4'h5: vec_of = `VEC_EXT3;
				4'h6: vec_of = `VEC_T1;
				4'h7: vec_of = `VEC_EXT4;
				4'h8: vec_of = `VEC_SERIAL;
				4'h9: vec_of = `VEC_EXT5;
				4'hA: vec_of = `VEC_T2;
				4'hB: vec_of = `VEC_EXT6;
				default: vec_of = `VEC_EXT0;
			endcase
		end
	endfunction

	// which flag the hardware clears when a source is vectored
	reg [11:0] clr_mask;
	always @* begin
		clr_mask = 12'h000;
		clr_mask[sel_src_q] = 1'b1;
		clr_mask = clr_mask & {1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
			1'b1, enable_q[`EN_EDGE1_BIT], 1'b1, 1'b0,
			1'b0, enable_q[`EN_EDGE0_BIT]};
	end

	// sampling, arbitration and call sequencing
	always @(posedge aclk) begin
		if (!aresetn) begin
			captured_q <= 12'h000;
			in_prog_q <= 4'h0;
			sel_src_q <= 4'h0;
			sel_lvl_q <= 2'h0;
			stall_q <= 1'b0;
			call_req <= 1'b0;
			call_vector <= 16'h0000;
			flag_clear <= 12'h000;
		end else if (clk_en) begin
			flag_clear <= 12'h000;
			if (flag_sample_point) begin
				captured_q <= gated_req;
				if (final_cycle)
					stall_q <= status_change_insn;
			end
			if (call_req && call_ack) begin
				call_req <= 1'b0;
				in_prog_q[sel_lvl_q] <= 1'b1;
				flag_clear <= clr_mask;
			end else if ((!call_req && grant) || overtake) begin
				call_req <= 1'b1;
				sel_src_q <= win_src;
				sel_lvl_q <= win_lvl;
				call_vector <= vec_of(win_src);
			end
			if (return_from_interrupt && busy && !(call_req && call_ack))
				in_prog_q[top_lvl] <= 1'b0;
		end
	end

	// register bus: write channel
	wire wr_go;
	assign wr_go = clk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;

	always @(posedge aclk) begin
		if (!aresetn) begin
			prio_low_q <= `PRIO_RESET;
			prio_high_q <= `PRIO_RESET;
			enable_q <= `ENABLE_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (s_axi_awaddr)
					A_PLOW:
						if (s_axi_wstrb[0])
							prio_low_q <= s_axi_wdata[5:0];
					A_PHIGH:
						if (s_axi_wstrb[0])
							prio_high_q <= s_axi_wdata[5:0];
					A_EN: begin
						if (s_axi_wstrb[0])
							enable_q[7:0] <= s_axi_wdata[7:0];
						if (s_axi_wstrb[1])
							enable_q[12:8] <= s_axi_wdata[12:8];
						if (s_axi_wstrb[2])
							enable_q[17:16] <= s_axi_wdata[17:16];
					end
					A_STAT: ;
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

	// register bus: read channel
	assign s_axi_arready = clk_en && !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				case (s_axi_araddr)
					A_PLOW: s_axi_rdata[5:0] <= prio_low_q;
					A_PHIGH: s_axi_rdata[5:0] <= prio_high_q;
					A_EN: begin
						s_axi_rdata[12:0] <= enable_q[12:0];
						s_axi_rdata[17:16] <= enable_q[17:16];
					end
					// in-progress levels, pending call, selected source
					A_STAT: s_axi_rdata <= {8'h00, captured_q, sel_lvl_q,
						sel_src_q, call_req, stall_q, in_prog_q};
					default: s_axi_rresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

endmodule // four_level_interrupt_priority_unit

`default_nettype wire

// [src/ilpu_consts.vh]
// constants for the four-level interrupt priority unit
`ifndef ILPU_CONSTS_VH
`define ILPU_CONSTS_VH
// register indices as printed or chosen; byte address = 4 * index
`define IDX_PRIO_LOW      8'hA9
`define IDX_PRIO_HIGH     8'hB9
`define IDX_ENABLE        8'hA8
`define IDX_STATUS        8'hAA
`define ADDR_W            10
`define PRIO_BITS         6
`define PRIO_RESET        6'h00
`define ENABLE_RESET      18'h00000
`define EN_GLOBAL_BIT     12
`define EN_EDGE0_BIT      16
`define EN_EDGE1_BIT      17
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
// source indices, arbitration order
`define SRC_EXT0          4'h0
`define SRC_ADC           4'h1
`define SRC_EXT1          4'h4
// vectors
`define VEC_EXT0          16'h0003
`define VEC_T0            16'h000B
`define VEC_EXT1          16'h0013
`define VEC_T1            16'h001B
`define VEC_SERIAL        16'h0023
`define VEC_T2            16'h002B
`define VEC_ADC           16'h0043
`define VEC_EXT2          16'h004B
`define VEC_EXT3          16'h0053
`define VEC_EXT4          16'h005B
`define VEC_EXT5          16'h0063
`define VEC_EXT6          16'h006B
`endif
